// file: hdl/hbfl_defines.svh
// Purpose: shared constants of the half-bridge fault latch
// Assumes: 16-bit control frame, 25 MHz core clock
// Notes: times are in microseconds, counts are derived from them
`ifndef HBFL_DEFINES_SVH
`define HBFL_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// frame fields
`define HBFL_FRAME_W 16
`define HBFL_BIT_SRR 0
`define HBFL_BIT_OCD 13
`define HBFL_BIT_ULD 14
`define HBFL_BIT_OVERVOLTAGE_LOCKOUT_ENABLE 15

////////////////////////////////////////////////////////////////////////////////
// geometry and timing
`define HBFL_NCH 6
`define HBFL_TMR_W 14
`define HBFL_CLK_MHZ 25
`define HBFL_OC_LONG_US 200
`define HBFL_OC_SHORT_US 25
`define HBFL_UL_US 350

`endif

// file: hdl/hbfl_pkg.sv
// Purpose: types of the half-bridge fault latch
// Assumes: six channels
// Notes: constants live in hbfl_defines.svh
`include "hbfl_defines.svh"

package hbfl_pkg;
	// one bit per half-bridge channel
	typedef logic [`HBFL_NCH-1:0] hbfl_chan_t;
	// delay timer count
	typedef logic [`HBFL_TMR_W-1:0] hbfl_count_t;
endpackage : hbfl_pkg

// file: hdl/hbfl_timer.sv
// Purpose: fault persistence timer
// Assumes: run is synchronous to core_clk
// Notes: limit is captured at start so a later change does not disturb a running delay
`include "hbfl_defines.svh"

module hbfl_timer import hbfl_pkg::*; #(
	parameter int W = `HBFL_TMR_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control
	input wire logic run,
	input wire logic [W-1:0] limit,
	// result
	output logic expired
);

	logic [W-1:0] count_reg;
	logic [W-1:0] limit_reg;
	logic busy_reg;

	////////////////////////////////////////////////////////////////////////////
	// count while the fault persists, restart when it goes away
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= '0;
			limit_reg <= '0;
			busy_reg <= 1'b0;
		end else if (!run) begin
			count_reg <= '0;
			busy_reg <= 1'b0;
		end else if (!busy_reg) begin
			busy_reg <= 1'b1;
			limit_reg <= limit; // frozen for this delay
			count_reg <= W'(1);
		end else if (count_reg < limit_reg) begin
			count_reg <= count_reg + W'(1);
		end
	end

	// level while run holds past the limit
	assign expired = busy_reg && run && (count_reg >= limit_reg);

endmodule : hbfl_timer

// file: hdl/hbfl_fault_latch.sv
// Purpose: fault supervision and driver gating for six half-bridge channels
// Assumes: frame_valid and frame_data come from core_clk logic; detector inputs are asynchronous
// Notes: high impedance is shown as both switches of a channel off
`include "hbfl_defines.svh"

module hbfl_fault_latch import hbfl_pkg::*; #(
	parameter int OC_LONG_CYC = `HBFL_OC_LONG_US * `HBFL_CLK_MHZ,
	parameter int UL_CYC = `HBFL_UL_US * `HBFL_CLK_MHZ
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control frame from the serial link
	input wire logic frame_valid,
	input wire logic [`HBFL_FRAME_W-1:0] frame_data,
	// programmed switch states
	input wire logic [`HBFL_NCH-1:0] high_side_switch_cmd,
	input wire logic [`HBFL_NCH-1:0] low_side_switch_cmd,
	// analog detectors, asynchronous
	input wire logic [`HBFL_NCH-1:0] overcurrent_det,
	input wire logic [`HBFL_NCH-1:0] underload_det,
	input wire logic overvoltage_det,
	input wire logic undervoltage_lockout,
	input wire logic supply_below_hyst,
	input wire logic thermal_warn_det,
	input wire logic thermal_shutdown_det,
	// driver gates
	output hbfl_chan_t high_side_switch_reg,
	output hbfl_chan_t low_side_switch_reg,
	output hbfl_chan_t current_limit_en_reg,
	// status
	output hbfl_chan_t latched_off_reg,
	output logic overcurrent_flag_reg,
	output logic underload_flag_reg,
	output logic supply_fail_flag_reg,
	output logic thermal_warning_flag_reg
);

	localparam int NCH = `HBFL_NCH;
	localparam int SW = 2 * NCH + 5;
	localparam int OC_SHORT_CYC = `HBFL_OC_SHORT_US * `HBFL_CLK_MHZ;

	////////////////////////////////////////////////////////////////////////////
	// two-flop synchroniser for every detector input
	logic [SW-1:0] meta_reg;
	logic [SW-1:0] sync_reg;
	hbfl_chan_t oc_s;
	hbfl_chan_t ul_s;
	logic ov_s;
	logic uv_s;
	logic hyst_s;
	logic tw_s;
	logic tsd_s;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= {overcurrent_det, underload_det, overvoltage_det, undervoltage_lockout,
				supply_below_hyst, thermal_warn_det, thermal_shutdown_det};
			sync_reg <= meta_reg;
		end
	end

	assign {oc_s, ul_s, ov_s, uv_s, hyst_s, tw_s, tsd_s} = sync_reg;

	////////////////////////////////////////////////////////////////////////////
	// configuration bits taken from each valid frame
	logic ocd_sel_reg;
	logic ul_en_reg;
	logic overvoltage_lockout_enable_en_reg;
	logic srr_pulse;

	assign srr_pulse = frame_valid && frame_data[`HBFL_BIT_SRR];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ocd_sel_reg <= 1'b0;
			ul_en_reg <= 1'b0;
			overvoltage_lockout_enable_en_reg <= 1'b0;
		end else if (frame_valid) begin
			ocd_sel_reg <= frame_data[`HBFL_BIT_OCD];
			ul_en_reg <= frame_data[`HBFL_BIT_ULD];
			overvoltage_lockout_enable_en_reg <= frame_data[`HBFL_BIT_OVERVOLTAGE_LOCKOUT_ENABLE];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-channel overcurrent timers, delay chosen at start
	hbfl_chan_t drv;
	hbfl_chan_t oc_run;
	hbfl_chan_t oc_exp;
	hbfl_count_t oc_limit;

	assign drv = high_side_switch_reg | low_side_switch_reg;
	assign oc_run = oc_s & drv & ~latched_off_reg;
	assign oc_limit = ocd_sel_reg ? hbfl_count_t'(OC_SHORT_CYC) : hbfl_count_t'(OC_LONG_CYC);

	for (genvar i = 0; i < NCH; i++) begin : g_oc
		hbfl_timer #(.W(`HBFL_TMR_W)) u_oc_timer (
			.core_clk(core_clk),
			.sys_rst(sys_rst),
			.run(oc_run[i]),
			.limit(oc_limit),
			.expired(oc_exp[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// one global underload timer shared by all channels
	hbfl_chan_t ul_hit;
	logic ul_exp;

	assign ul_hit = ul_s & drv & ~latched_off_reg;

	hbfl_timer #(.W(`HBFL_TMR_W)) u_ul_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.run(|ul_hit),
		.limit(hbfl_count_t'(UL_CYC)),
		.expired(ul_exp)
	);

	////////////////////////////////////////////////////////////////////////////
	// latched-off drivers; a new trip wins over a reset request
	hbfl_chan_t trip;

	assign trip = oc_exp | ((ul_exp && ul_en_reg) ? ul_hit : '0);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			latched_off_reg <= '0;
		end else if (srr_pulse) begin
			latched_off_reg <= trip;
		end else begin
			latched_off_reg <= latched_off_reg | trip;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// latched status flags, set beats clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			overcurrent_flag_reg <= 1'b0;
			underload_flag_reg <= 1'b0;
			thermal_warning_flag_reg <= 1'b0;
		end else begin
			overcurrent_flag_reg <= (|oc_exp) || (overcurrent_flag_reg && !srr_pulse);
			underload_flag_reg <= ul_exp || (underload_flag_reg && !srr_pulse);
			thermal_warning_flag_reg <= tw_s || (thermal_warning_flag_reg && !srr_pulse);
		end
	end

	// supply fail also needs the supply back below hysteresis
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			supply_fail_flag_reg <= 1'b0;
		end else if (ov_s || uv_s) begin
			supply_fail_flag_reg <= 1'b1;
		end else if (srr_pulse && hyst_s) begin
			supply_fail_flag_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// driver gates; the programmed state is never altered, so a lockout recovers without a clear request
	logic block_all;

	assign block_all = uv_s || tsd_s || (ov_s && overvoltage_lockout_enable_en_reg);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			high_side_switch_reg <= '0;
			low_side_switch_reg <= '0;
		end else if (block_all) begin
			high_side_switch_reg <= '0;
			low_side_switch_reg <= '0;
		end else begin
			// no cross-check of pairs: shoot-through is the host's to avoid
			high_side_switch_reg <= high_side_switch_cmd & ~latched_off_reg;
			low_side_switch_reg <= low_side_switch_cmd & ~latched_off_reg;
		end
	end

	// analog limit is never gated by the delay select
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			current_limit_en_reg <= '1;
		end else begin
			current_limit_en_reg <= '1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_oc_long;
		$rose(oc_run[0]) && !ocd_sel_reg |=> !oc_exp[0] [*8];
	endproperty
	a_oc_long: assert property (p_oc_long) else $error("long overcurrent delay ended early");

	property p_oc_latch;
		oc_exp != '0 |=> ((latched_off_reg & $past(oc_exp)) == $past(oc_exp)) && overcurrent_flag_reg;
	endproperty
	a_oc_latch: assert property (p_oc_latch) else $error("overcurrent did not latch");

	property p_limit_on;
		current_limit_en_reg == '1;
	endproperty
	a_limit_on: assert property (p_limit_on) else $error("current limit disabled");

	property p_ul_keep;
		ul_exp && !ul_en_reg && oc_exp == '0 && !srr_pulse |=> underload_flag_reg && $stable(latched_off_reg);
	endproperty
	a_ul_keep: assert property (p_ul_keep) else $error("underload changed drivers");

	property p_ul_off;
		ul_exp && ul_en_reg |=> underload_flag_reg && ((latched_off_reg & $past(ul_hit)) == $past(ul_hit));
	endproperty
	a_ul_off: assert property (p_ul_off) else $error("underload did not latch off");

	property p_clear_cause;
		$fell(underload_flag_reg) || $fell(overcurrent_flag_reg) |-> $past(srr_pulse);
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("flag cleared without request");

	property p_ov_off;
		ov_s && overvoltage_lockout_enable_en_reg |=> high_side_switch_reg == '0 && low_side_switch_reg == '0;
	endproperty
	a_ov_off: assert property (p_ov_off) else $error("drivers on in overvoltage lockout");

	property p_psf_clear;
		$fell(supply_fail_flag_reg) |-> $past(srr_pulse) && $past(hyst_s);
	endproperty
	a_psf_clear: assert property (p_psf_clear) else $error("supply fail cleared early");

	property p_uv_off;
		uv_s |=> high_side_switch_reg == '0 && low_side_switch_reg == '0 && supply_fail_flag_reg;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("undervoltage not handled");

	property p_tsd_off;
		tsd_s |=> drv == '0;
	endproperty
	a_tsd_off: assert property (p_tsd_off) else $error("drivers on in thermal shutdown");

	property p_tw_hold;
		thermal_warning_flag_reg && !srr_pulse |=> thermal_warning_flag_reg;
	endproperty
	a_tw_hold: assert property (p_tw_hold) else $error("thermal warning lost");

	property p_srr_clear;
		srr_pulse && !tw_s |=> !thermal_warning_flag_reg;
	endproperty
	a_srr_clear: assert property (p_srr_clear) else $error("reset request ignored");

	c_oc_trip: cover property (oc_exp != '0 ##1 latched_off_reg != '0);
	c_srr: cover property (latched_off_reg != '0 ##1 srr_pulse ##1 latched_off_reg == '0);
	c_uv: cover property (uv_s ##1 supply_fail_flag_reg);

endmodule : hbfl_fault_latch

// file: tb/hbfl_host_model.sv
// Purpose: host side of the control link, issuing frames and switch commands
// Assumes: frames are one-cycle pulses on core_clk, driven at the falling edge
// Notes: frame_data is scrambled between frames so a stale word never looks valid
`include "hbfl_defines.svh"

module hbfl_host_model (
	// clock
	input wire logic core_clk,
	// control frame
	output logic frame_valid,
	output logic [`HBFL_FRAME_W-1:0] frame_data,
	// programmed switch states
	output logic [`HBFL_NCH-1:0] high_side_switch_cmd,
	output logic [`HBFL_NCH-1:0] low_side_switch_cmd
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// idle state at time zero
	initial begin
		frame_valid = 1'b0;
		frame_data = 16'h0000;
		high_side_switch_cmd = 6'h00;
		low_side_switch_cmd = 6'h00;
	end

	// one frame; bit 0 set asks for a clear of latched status
	task automatic send(input logic [`HBFL_FRAME_W-1:0] d);
		@(negedge core_clk);
		frame_valid = 1'b1;
		frame_data = d;
		@(negedge core_clk);
		frame_valid = 1'b0;
		frame_data = ~d;
	endtask : send

	// low side masked where high is on, so a pair never shoots through
	task automatic set_cmd(input logic [`HBFL_NCH-1:0] h, input logic [`HBFL_NCH-1:0] l);
		high_side_switch_cmd = h;
		low_side_switch_cmd = l & ~h;
	endtask : set_cmd
endmodule : hbfl_host_model

// file: tb/tb.sv
// Purpose: self-checking bench of the half-bridge fault latch
// Assumes: long delays shortened by parameter, short overcurrent delay fixed
// Notes: latencies are 2 sync edges, then the timer, then one edge to latch
`include "hbfl_defines.svh"

module tb import hbfl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int OC_LONG = 40;
	localparam int UL = 30;
	localparam int OC_SHORT = `HBFL_OC_SHORT_US * `HBFL_CLK_MHZ;

	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic frame_valid;
	logic [15:0] frame_data;
	hbfl_chan_t hs_cmd, ls_cmd, oc = 6'h00, ul = 6'h00;
	logic ov = 1'b0, uv = 1'b0, hyst = 1'b1, tw = 1'b0, tsd = 1'b0;
	hbfl_chan_t hs, ls, clim, lat;
	logic oc_f, ul_f, sf_f, tw_f;
	logic [15:0] cfg = 16'h0000;
	int errors = 0;
	int n_tests = 0;

	////////////////////////////////////////////////////////////////////////////////
	// clock, partner and design
	initial begin
		forever #20 core_clk = ~core_clk;
	end

	hbfl_host_model host (.core_clk(core_clk), .frame_valid(frame_valid), .frame_data(frame_data),
		.high_side_switch_cmd(hs_cmd), .low_side_switch_cmd(ls_cmd));

	hbfl_fault_latch #(.OC_LONG_CYC(OC_LONG), .UL_CYC(UL)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.frame_valid(frame_valid), .frame_data(frame_data), .high_side_switch_cmd(hs_cmd),
		.low_side_switch_cmd(ls_cmd), .overcurrent_det(oc), .underload_det(ul), .overvoltage_det(ov),
		.undervoltage_lockout(uv), .supply_below_hyst(hyst), .thermal_warn_det(tw),
		.thermal_shutdown_det(tsd), .high_side_switch_reg(hs), .low_side_switch_reg(ls),
		.current_limit_en_reg(clim), .latched_off_reg(lat), .overcurrent_flag_reg(oc_f),
		.underload_flag_reg(ul_f), .supply_fail_flag_reg(sf_f), .thermal_warning_flag_reg(tw_f));

	////////////////////////////////////////////////////////////////////////////////
	// shared helpers
	// wide enough for the longest concatenation compared below
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// n rising edges, then settle at the falling edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : tick

	task automatic configure(input logic [15:0] c);
		cfg = c;
		host.send(c);
		tick(1);
	endtask : configure

	// clear request once detectors have settled; everything back to programmed
	task automatic restore;
		tick(3);
		host.send(cfg | 16'h0001);
		check("status", {lat, oc_f, ul_f, sf_f, tw_f}, 16'h0000);
		tick(1);
		check("switches", {hs, ls}, {6'h15, 6'h2a});
	endtask : restore

	task automatic report_and_stop;
		if (errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic oc_run(input logic [15:0] c, input int lim);
		configure(c);
		oc = 6'h01;
		tick(2 + lim);
		check("oc early", {lat, oc_f}, 16'h0000);
		tick(1);
		check("oc latch", {lat, oc_f}, {6'h01, 1'b1});
		oc = 6'h00;
		tick(1);
		check("oc gate", {hs, ls}, {6'h14, 6'h2a});
		check("limit", clim, 16'h003f);
		tick(3);
		host.send(cfg);
		check("no clear", lat, 16'h0001);
		restore();
	endtask : oc_run

	task automatic ul_run(input logic [15:0] c, input hbfl_chan_t exp_lat, input hbfl_chan_t exp_ls);
		configure(c);
		ul = 6'h02;
		tick(2 + UL);
		check("ul early", ul_f, 16'h0000);
		tick(1);
		check("ul latch", {lat, ul_f}, {exp_lat, 1'b1});
		tick(1);
		check("ul gate", {hs, ls}, {6'h15, exp_ls});
		ul = 6'h00;
		restore();
	endtask : ul_run

	task automatic ov_run(input logic [15:0] c, input hbfl_chan_t h, input hbfl_chan_t l);
		configure(c);
		ov = 1'b1;
		tick(3);
		check("ov", {hs, ls, sf_f}, {h, l, 1'b1});
		ov = 1'b0;
		hyst = 1'b0;
		tick(3);
		check("ov resume", {hs, ls}, {6'h15, 6'h2a});
		host.send(cfg | 16'h0001);
		check("ov hyst", sf_f, 16'h0001);
		hyst = 1'b1;
		restore();
	endtask : ov_run

	task automatic lockouts;
		uv = 1'b1;
		tick(2);
		check("uv pre", hs, 16'h0015);
		tick(1);
		check("uv", {hs, ls, sf_f}, {12'h000, 1'b1});
		uv = 1'b0;
		tick(3);
		check("uv resume", {hs, ls}, {6'h15, 6'h2a});
		restore();
		tsd = 1'b1;
		tick(3);
		check("tsd", {hs, ls, oc_f, ul_f, sf_f, tw_f}, 16'h0000);
		tsd = 1'b0;
		tick(3);
		check("tsd resume", {hs, ls}, {6'h15, 6'h2a});
		tw = 1'b1;
		tick(3);
		check("tw", {hs, tw_f}, {6'h15, 1'b1});
		tw = 1'b0;
		tick(5);
		check("tw held", tw_f, 16'h0001);
		restore();
	endtask : lockouts

	////////////////////////////////////////////////////////////////////////////////
	// main sequence; reset held two cycles
	initial begin
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		check("reset", {hs, ls, lat, clim}, {18'h0_0000, 6'h3f});
		sys_rst = 1'b0;
		host.set_cmd(6'h15, 6'h2a);
		tick(2);
		check("programmed", {hs, ls}, {6'h15, 6'h2a});
		oc_run(16'h0000, OC_LONG);
		oc_run(16'h2000, OC_SHORT);
		ul_run(16'h0000, 6'h00, 6'h2a);
		ul_run(16'h4000, 6'h02, 6'h28);
		ov_run(16'h0000, 6'h15, 6'h2a);
		ov_run(16'h8000, 6'h00, 6'h00);
		lockouts();
		// mid-run reset drops every latch and the configuration
		tw = 1'b1;
		tick(3);
		check("tw again", tw_f, 16'h0001);
		tw = 1'b0;
		sys_rst = 1'b1;
		tick(1);
		check("mid reset", {hs, ls, lat, clim, tw_f}, {18'h0_0000, 6'h3f, 1'b0});
		sys_rst = 1'b0;
		tick(1);
		check("after reset", {hs, ls, tw_f}, {6'h15, 6'h2a, 1'b0});
		report_and_stop();
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		errors++;
		report_and_stop();
	end
endmodule : tb
